// ==== design/spi_master_defs.svh ====
// Constants of the SPI master: register map, field positions, reset values, timing.
// Included by the package file and by the SPI master module; definitions only.
`ifndef SPI_MASTER_DEFS_SVH
`define SPI_MASTER_DEFS_SVH

// Register byte addresses on APB
`define ADDR_TX_DATA 8'h00
`define ADDR_RX_DATA 8'h04
`define ADDR_TX_STATUS 8'h08
`define ADDR_RX_STATUS 8'h0c
`define ADDR_TX_MASK 8'h10
`define ADDR_RX_MASK 8'h14
`define ADDR_CONFIG 8'h18

// Transmit status bit positions
`define TXS_DONE 0
`define TXS_EMPTY 1
`define TXS_NOT_FULL 2
`define TXS_WORD_DONE 3
`define TXS_IDLE 4
`define STS_IRQ 7

// Receive status bit positions
`define RXS_FULL 4
`define RXS_NOT_EMPTY 5
`define RXS_OVERRUN 6

// Configuration register fields
`define CFG_LEN_LSB 0
`define CFG_LEN_MSB 4
`define CFG_MODE_LSB 5
`define CFG_MODE_MSB 6
`define CFG_ENGINE_RESET 7
`define CFG_DIV_LSB 8
`define CFG_DIV_MSB 23

// Word length limits and default
`define WORD_LEN_MIN 5'h03
`define WORD_LEN_MAX 5'h10
`define WORD_LEN_DEFAULT 5'h08
`define MODE_DEFAULT 2'h0

// Initial interrupt masks
`define TX_INIT_IRQ_MASK 7'h00
`define RX_INIT_IRQ_MASK 7'h00

// Timing: half a bit period in component clock cycles
`define CLK_HZ 10000000
`define BIT_RATE_BPS 1000000
`define HALF_BIT_CYCLES (`CLK_HZ / (2 * `BIT_RATE_BPS))

// Queue geometry
`define DATA_W 16
`define QUEUE_DEPTH 4

`endif

// ==== design/spi_master_pkg.sv ====
// Types shared by the SPI master modules.
// Assumes spi_master_defs.svh sits on the include path.
`include "spi_master_defs.svh"

package spi_master_pkg;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_SHIFT = 2'b11,
    ST_END = 2'b10
  } xfer_state_e;

  typedef struct packed
  {
    logic sclk;
    logic mosi;
    logic ss_n;
  } spi_out_s;

  typedef struct packed
  {
    logic [4:0] word_len;
    logic [1:0] mode;
    logic [15:0] half_div;
  } spi_cfg_s;

endpackage

// ==== design/spi_master_status_fifo.sv ====
// SPI master transfer engine with transmit and receive word queues and two status registers.
// Assumes an APB master on the register side and SPI slaves on sclk, mosi, miso and ss_n.
// Functional notes
// - Word-complete sticky flag sets as the last bit of a word is driven.
// - Transfer-done sets at the last latching edge when the transmit queue is empty.
// - Transmit-empty bit is live: high when no word waits.
// - Transmit-has-room bit is live: high when the queue accepts another word.
// - Idle bit high in idle; idle left only when transmit data is seen.
// - Receive overrun sticky flag sets when a word arrives at a full queue.
// - Receive-not-empty is live: at least one word held.
// - Receive-full is live: every entry occupied.
// - Bit 7 of each status register is OR of masked status bits.
// - Sticky bits hold until their status register is read, then clear; transfer-done also clears when a word loads into the shifter.
// - Defaults: 8-bit words, mode 0, internal clock for 1 Mbps.
// - Mode numbers: 0=ph0/pol0, 1=ph0/pol1, 2=ph1/pol0, 3=ph1/pol1.
// - Slave select low when transmission starts, high after queue drains.
// - Loading a word into the shifter frees a queue entry.
// - Transmit-empty sets when the final word loads into the shifter.
// - First received word sets receive-not-empty; word-complete sets earlier, as its last bit is driven.
// - Each receive-data read pops one word.
// - Engine steps on half-bit ticks: two ticks per serial bit.
// - Word length configurable from 3 to 16 bits.
`timescale 1ns/1ns
`include "spi_master_defs.svh"

module spi_master_status_fifo
  import spi_master_pkg::*;
#(
  parameter int DW = `DATA_W,
  parameter int DEPTH = `QUEUE_DEPTH
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic miso,
  output spi_out_s spi_o,
  output logic tx_irq,
  output logic rx_irq
);

  localparam logic [5:0] DW6 = 6'(DW);

  typedef struct packed
  {
    xfer_state_e st;
    logic [15:0] div_cnt;
    logic [4:0] half;
    logic [DW-1:0] txsh;
    logic [DW-1:0] rxsh;
    spi_out_s spi;
    spi_cfg_s cfg;
    logic done_st;
    logic wc_st;
    logic ovr_st;
    logic [6:0] tx_mask;
    logic [6:0] rx_mask;
    logic [31:0] prdata;
    logic miso_s1;
    logic miso_s2;
  } state_s;

  state_s s_ff;
  state_s nxt_s;

  logic [DW-1:0] tx_head;
  logic [DW-1:0] rx_head;
  logic tx_full;
  logic tx_empty;
  logic rx_full;
  logic rx_empty;
  logic tx_push;
  logic tx_pop;
  logic rx_push;
  logic rx_pop;
  logic [DW-1:0] rx_wdata;
  logic [7:0] tx_status;
  logic [7:0] rx_status;

  logic cpha;
  logic cpol;
  logic tick;
  logic load;
  logic latch_edge;
  logic rx_req;
  logic acc;
  logic mapped;
  logic engine_rst;
  logic [4:0] half_end;
  logic [4:0] drive_last;
  logic [4:0] latch_last;
  logic [DW-1:0] aligned;
  logic [31:0] rd_val;
  logic [4:0] len_wr;

  ////////////////////////////////////////////////////////////////////////////////
  // Queues

  word_fifo #(
    .WIDTH(DW),
    .DEPTH(DEPTH)
  ) tx_queue (
    .clk(clk),
    .resetn(resetn),
    .push(tx_push),
    .wdata(pwdata[DW-1:0]),
    .pop(tx_pop),
    .head(tx_head),
    .full(tx_full),
    .empty(tx_empty)
  );

  word_fifo #(
    .WIDTH(DW),
    .DEPTH(DEPTH)
  ) rx_queue (
    .clk(clk),
    .resetn(resetn),
    .push(rx_push),
    .wdata(rx_wdata),
    .pop(rx_pop),
    .head(rx_head),
    .full(rx_full),
    .empty(rx_empty)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Status registers and outputs

  always_comb
  begin
    tx_status = 8'h00;
    tx_status[`TXS_DONE] = s_ff.done_st;
    tx_status[`TXS_EMPTY] = tx_empty;
    tx_status[`TXS_NOT_FULL] = ~tx_full;
    tx_status[`TXS_WORD_DONE] = s_ff.wc_st;
    tx_status[`TXS_IDLE] = (s_ff.st == ST_IDLE);
    tx_status[`STS_IRQ] = |(tx_status[6:0] & s_ff.tx_mask);
    rx_status = 8'h00;
    rx_status[`RXS_FULL] = rx_full;
    rx_status[`RXS_NOT_EMPTY] = ~rx_empty;
    rx_status[`RXS_OVERRUN] = s_ff.ovr_st;
    rx_status[`STS_IRQ] = |(rx_status[6:0] & s_ff.rx_mask);
  end

  assign tx_irq = tx_status[`STS_IRQ];
  assign rx_irq = rx_status[`STS_IRQ];
  assign prdata = s_ff.prdata;
  assign spi_o = s_ff.spi;
  assign pready = 1'b1;
  assign acc = psel & penable;
  assign pslverr = acc & ~mapped;

  ////////////////////////////////////////////////////////////////////////////////
  // Register read mux

  always_comb
  begin
    rd_val = 32'h0;
    mapped = 1'b1;
    unique case (paddr)
      `ADDR_TX_DATA: rd_val = 32'h0;
      `ADDR_RX_DATA: rd_val = 32'(rx_head);
      `ADDR_TX_STATUS: rd_val = 32'(tx_status);
      `ADDR_RX_STATUS: rd_val = 32'(rx_status);
      `ADDR_TX_MASK: rd_val = 32'(s_ff.tx_mask);
      `ADDR_RX_MASK: rd_val = 32'(s_ff.rx_mask);
      `ADDR_CONFIG:
      begin
        rd_val[`CFG_LEN_MSB:`CFG_LEN_LSB] = s_ff.cfg.word_len;
        rd_val[`CFG_MODE_MSB:`CFG_MODE_LSB] = s_ff.cfg.mode;
        rd_val[`CFG_DIV_MSB:`CFG_DIV_LSB] = s_ff.cfg.half_div;
      end
      default: mapped = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    nxt_s = s_ff;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_pop = 1'b0;
    tick = 1'b0;
    load = 1'b0;
    rx_req = 1'b0;
    engine_rst = 1'b0;
    rx_wdata = {s_ff.rxsh[DW-2:0], s_ff.miso_s2};

    nxt_s.miso_s1 = miso;
    nxt_s.miso_s2 = s_ff.miso_s1;

    cpha = s_ff.cfg.mode[1];
    cpol = s_ff.cfg.mode[0];
    half_end = 5'({1'b0, s_ff.cfg.word_len, 1'b0} - 7'h01);
    drive_last = cpha ? half_end - 5'h01 : half_end - 5'h02;
    latch_last = cpha ? half_end : half_end - 5'h01;
    latch_edge = (s_ff.half[0] == cpha);
    aligned = tx_head << (DW6 - {1'b0, s_ff.cfg.word_len});

    // Half-bit tick: the serial bit spans two ticks
    if (s_ff.st == ST_IDLE)
    begin
      nxt_s.div_cnt = 16'h0000;
    end
    else if ({1'b0, s_ff.div_cnt} + 17'h00001 >= {1'b0, s_ff.cfg.half_div})
    begin
      tick = 1'b1;
      nxt_s.div_cnt = 16'h0000;
    end
    else
    begin
      nxt_s.div_cnt = s_ff.div_cnt + 16'h0001;
    end

    // APB: read data captured in setup, side effects at the completing edge
    if (psel && !penable)
    begin
      nxt_s.prdata = rd_val;
    end
    if (acc && !pwrite && paddr == `ADDR_TX_STATUS)
    begin
      nxt_s.done_st = s_ff.done_st & ~s_ff.prdata[`TXS_DONE];
      nxt_s.wc_st = s_ff.wc_st & ~s_ff.prdata[`TXS_WORD_DONE];
    end
    if (acc && !pwrite && paddr == `ADDR_RX_STATUS)
    begin
      nxt_s.ovr_st = s_ff.ovr_st & ~s_ff.prdata[`RXS_OVERRUN];
    end
    rx_pop = acc & ~pwrite & (paddr == `ADDR_RX_DATA) & ~rx_empty;
    tx_push = acc & pwrite & (paddr == `ADDR_TX_DATA) & ~tx_full;
    if (acc && pwrite && paddr == `ADDR_TX_MASK)
    begin
      nxt_s.tx_mask = pwdata[6:0];
    end
    if (acc && pwrite && paddr == `ADDR_RX_MASK)
    begin
      nxt_s.rx_mask = pwdata[6:0];
    end
    len_wr = pwdata[`CFG_LEN_MSB:`CFG_LEN_LSB];
    if (acc && pwrite && paddr == `ADDR_CONFIG)
    begin
      if (len_wr < `WORD_LEN_MIN)
      begin
        nxt_s.cfg.word_len = `WORD_LEN_MIN;
      end
      else if (len_wr > `WORD_LEN_MAX)
      begin
        nxt_s.cfg.word_len = `WORD_LEN_MAX;
      end
      else
      begin
        nxt_s.cfg.word_len = len_wr;
      end
      nxt_s.cfg.mode = pwdata[`CFG_MODE_MSB:`CFG_MODE_LSB];
      nxt_s.cfg.half_div = pwdata[`CFG_DIV_MSB:`CFG_DIV_LSB];
      engine_rst = pwdata[`CFG_ENGINE_RESET];
    end

    // Transfer state machine
    unique case (s_ff.st)
      ST_IDLE:
      begin
        nxt_s.spi.sclk = cpol;
        nxt_s.spi.ss_n = 1'b1;
        if (!tx_empty)
        begin
          load = 1'b1;
          nxt_s.spi.ss_n = 1'b0;
          nxt_s.st = ST_LOAD;
        end
      end
      ST_LOAD:
      begin
        if (tick)
        begin
          nxt_s.st = ST_SHIFT;
          nxt_s.half = 5'h00;
        end
      end
      ST_SHIFT:
      begin
        if (tick)
        begin
          nxt_s.spi.sclk = ~s_ff.spi.sclk;
          nxt_s.half = s_ff.half + 5'h01;
          if (latch_edge)
          begin
            nxt_s.rxsh = rx_wdata;
          end
          else if (cpha || s_ff.half != half_end)
          begin
            nxt_s.spi.mosi = s_ff.txsh[DW-1];
            nxt_s.txsh = s_ff.txsh << 1;
          end
          if (s_ff.half == drive_last)
          begin
            nxt_s.wc_st = 1'b1;
          end
          if (s_ff.half == latch_last)
          begin
            rx_req = 1'b1;
            if (tx_empty)
            begin
              nxt_s.done_st = 1'b1;
            end
          end
          if (s_ff.half == half_end)
          begin
            if (!tx_empty)
            begin
              load = 1'b1;
              nxt_s.st = ST_LOAD;
            end
            else
            begin
              nxt_s.st = ST_END;
            end
          end
        end
      end
      ST_END:
      begin
        if (tick)
        begin
          nxt_s.spi.ss_n = 1'b1;
          nxt_s.st = ST_IDLE;
        end
      end
    endcase

    // Word handoff from the transmit queue into the shifter
    if (load)
    begin
      tx_pop = 1'b1;
      nxt_s.rxsh = '0;
      nxt_s.done_st = 1'b0;
      if (cpha)
      begin
        nxt_s.txsh = aligned;
      end
      else
      begin
        nxt_s.spi.mosi = aligned[DW-1];
        nxt_s.txsh = aligned << 1;
      end
    end

    // Received word into the receive queue
    if (rx_req)
    begin
      if (rx_full)
      begin
        nxt_s.ovr_st = 1'b1;
      end
      else
      begin
        rx_push = 1'b1;
      end
    end

    // Engine reset drops the word in flight but keeps both queues
    if (engine_rst)
    begin
      nxt_s.st = ST_IDLE;
      nxt_s.half = 5'h00;
      nxt_s.spi.ss_n = 1'b1;
      nxt_s.spi.sclk = cpol;
      tx_pop = 1'b0;
      rx_push = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_ff <= '0;
      s_ff.st <= ST_IDLE;
      s_ff.spi.ss_n <= 1'b1;
      s_ff.cfg.word_len <= `WORD_LEN_DEFAULT;
      s_ff.cfg.mode <= `MODE_DEFAULT;
      s_ff.cfg.half_div <= 16'(`HALF_BIT_CYCLES);
      s_ff.tx_mask <= `TX_INIT_IRQ_MASK;
      s_ff.rx_mask <= `RX_INIT_IRQ_MASK;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

endmodule

// ==== design/word_fifo.sv ====
// Word queue with combinational head, full and empty.
// Assumes push is only given when not full and pop only when not empty.
`timescale 1ns/1ns

module word_fifo
  import spi_master_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic push,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic pop,
  output logic [WIDTH-1:0] head,
  output logic full,
  output logic empty
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  typedef struct packed
  {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
  } fifo_s;

  fifo_s s_ff;
  fifo_s nxt_s;

  assign head = s_ff.mem[s_ff.rp];
  assign full = (s_ff.cnt == FULL_CNT);
  assign empty = (s_ff.cnt == '0);

  always_comb
  begin
    nxt_s = s_ff;
    if (push)
    begin
      nxt_s.mem[s_ff.wp] = wdata;
      nxt_s.wp = (s_ff.wp == LAST) ? '0 : s_ff.wp + PW'(1);
    end
    if (pop)
    begin
      nxt_s.rp = (s_ff.rp == LAST) ? '0 : s_ff.rp + PW'(1);
    end
    if (push && !pop)
    begin
      nxt_s.cnt = s_ff.cnt + CW'(1);
    end
    else if (pop && !push)
    begin
      nxt_s.cnt = s_ff.cnt - CW'(1);
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_ff <= '0;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

endmodule

// ==== verification/spi_master_status_fifo_chk.sv ====
// Checker for the SPI master: APB answers, status coherence, link pacing.
// Assumes a bind from the bench top and a half-bit divider of 4 or more.
`timescale 1ns/1ns

module spi_master_status_fifo_chk
  import spi_master_pkg::*;
#(
  parameter int DW = 16,
  parameter int DEPTH = 4
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire spi_out_s spi_o,
  input wire logic tx_irq,
  input wire logic rx_irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  logic rd_tx;
  logic rd_rx;
  assign rd_tx = psel && !penable && paddr == 8'h08;
  assign rd_rx = psel && !penable && paddr == 8'h0c;

  ////////////////////////////////////////////////////////////////////////
  ready_high_a: assert property (pready) else $error("pready low");
  bad_addr_a: assert property (psel && penable && paddr > 8'h18 |-> pslverr) else $error("no slave error");
  tx_irq_a: assert property (rd_tx |=> prdata[7] == $past(tx_irq)) else $error("tx irq bit wrong");
  rx_irq_a: assert property (rd_rx |=> prdata[7] == $past(rx_irq)) else $error("rx irq bit wrong");
  tx_room_a: assert property (rd_tx |=> !prdata[1] || prdata[2]) else $error("empty without room");
  idle_flag_a: assert property (rd_tx |=> !prdata[4] || $past(spi_o.ss_n)) else $error("idle while selected");
  rx_full_a: assert property (rd_rx |=> !prdata[4] || prdata[5]) else $error("full yet empty");
  select_low_a: assert property (psel && penable && pwrite && paddr == 8'h00 && spi_o.ss_n
    |-> ##[1:4] !spi_o.ss_n) else $error("select not driven low");
  half_bit_a: assert property (!spi_o.ss_n && $changed(spi_o.sclk)
    |=> ($stable(spi_o.sclk) || spi_o.ss_n) [*3]) else $error("serial clock too fast");
  // Serial clock rests while deselected, except when a config write moves its idle level
  sclk_still_a: assert property (spi_o.ss_n && $past(spi_o.ss_n)
    && !$past(psel && penable && pwrite && paddr == 8'h18, 2) |-> $stable(spi_o.sclk))
    else $error("serial clock moved while deselected");
endmodule

// ==== verification/spi_slave_model.sv ====
// Behavioural SPI slave answering the master, MSB first, in any of the four modes.
// Assumes the bench holds mode and word length steady while selected.
`timescale 1ns/1ns

module spi_slave_model
(
  input wire logic ss_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic [1:0] mode,
  input wire logic [4:0] len,
  input wire logic [15:0] reply,
  output logic miso,
  output logic [15:0] got,
  output int nwords
);
  logic [15:0] sh;
  logic [15:0] rx;
  logic fresh;
  int cnt;

  // Answer word is the base reply plus the count of words done
  task automatic load;
    sh = (reply + nwords[15:0]) << (16 - len);
    fresh = 1'b1;
    cnt = 0;
  endtask

  initial
  begin
    miso = 1'b0;
    got = '0;
    rx = '0;
    nwords = 0;
  end

  always @(negedge ss_n)
  begin
    load();
    if (!mode[1])
    begin
      miso = sh[15];
      fresh = 1'b0;
    end
  end

  // Released line shows the inverse of its last bit
  always @(posedge ss_n)
    miso = ~miso;

  always @(sclk)
    if (!ss_n)
    begin
      if ((sclk != mode[0]) != mode[1])
      begin
        rx = {rx[14:0], mosi};
        cnt++;
        if (cnt == len)
        begin
          got = rx & 16'((17'h1 << len) - 17'h1);
          nwords++;
          load();
        end
      end
      else
      begin
        if (!fresh)
          sh = sh << 1;
        fresh = 1'b0;
        miso = sh[15];
      end
    end
endmodule

// ==== verification/tb_spi_master_status_fifo.sv ====
// Self-checking bench: APB master tasks, SPI slave model, random words.
// Assumes the design files, the slave model and the checker compile first.
`timescale 1ns/1ns

module tb_spi_master_status_fifo
  import spi_master_pkg::*;
;
  logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic pready, pslverr, miso, tx_irq, rx_irq;
  spi_out_s spi_o;
  logic [1:0] mode = 2'h0;
  logic [4:0] len = 5'h08;
  logic [15:0] reply = '0, got, m, w;
  int nwords, n, b, k, n_mismatch = 0, compares = 0, cyc = 0;

  always #50 clk = ~clk;

  spi_master_status_fifo DUT (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .miso, .spi_o, .tx_irq, .rx_irq);
  spi_slave_model slave (.ss_n(spi_o.ss_n), .sclk(spi_o.sclk), .mosi(spi_o.mosi), .mode, .len,
    .reply, .miso, .got, .nwords);

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] mk(input logic [4:0] l);
    return 16'((17'h1 << l) - 17'h1);
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("mismatches=%0d compares=%0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Cycles until the serial clock next changes
  task automatic gap(output int c);
    logic s;
    s = spi_o.sclk;
    c = 0;
    while (spi_o.sclk === s && c < 99)
    begin
      @(negedge clk);
      c++;
    end
  endtask

  // Wait for selection, then for the queue to drain
  task automatic drain;
    int c;
    c = 0;
    while (spi_o.ss_n !== 1'b0 && c < 9)
    begin
      @(negedge clk);
      c++;
    end
    while (spi_o.ss_n !== 1'b1 && c < 3000)
    begin
      @(negedge clk);
      c++;
    end
    repeat (3) @(negedge clk);
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h1fed));
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    apb(1'b0, 8'h08, 0);
    chk(r, 32'h16);
    apb(1'b0, 8'h0c, 0);
    chk(r, 32'h00);
    apb(1'b0, 8'h18, 0);
    chk(r, 32'h0508);
    apb(1'b0, 8'h1c, 0);
    chk(r, 32'h0);
    // Word length clamps at both ends
    apb(1'b1, 8'h18, 32'h051f);
    apb(1'b0, 8'h18, 0);
    chk(r, 32'h0510);
    apb(1'b1, 8'h18, 32'h0501);
    apb(1'b0, 8'h18, 0);
    chk(r, 32'h0503);
    // Every mode, word length extremes, 1 us and 800 ns bit periods
    for (k = 0; k < 8; k++)
    begin
      mode = k[1:0];
      len = (k == 2) ? 5'h03 : (k == 5) ? 5'h10 : 5'($urandom_range(3, 16));
      b = k[0] ? 4 : 5;
      reply = 16'($urandom);
      w = 16'($urandom);
      apb(1'b1, 8'h18, {8'h00, 16'(b), 1'b0, mode, len});
      m = nwords[15:0];
      apb(1'b1, 8'h00, {16'h0, w});
      gap(n);
      gap(n);
      chk(n, b);
      drain();
      chk(spi_o.sclk, mode[0]);
      chk(got, w & mk(len));
      apb(1'b0, 8'h04, 0);
      chk(r, (reply + m) & mk(len));
      apb(1'b0, 8'h08, 0);
      chk(r, 32'h1f);
    end
    // Full queues, overrun, sticky clear and masks
    mode = 2'h0;
    len = 5'h08;
    apb(1'b1, 8'h18, 32'h0508);
    apb(1'b1, 8'h10, 32'h08);
    apb(1'b1, 8'h14, 32'h40);
    m = nwords[15:0];
    for (k = 0; k < 6; k++)
      apb(1'b1, 8'h00, 32'h5a + k);
    apb(1'b0, 8'h08, 0);
    chk(r, 32'h00);
    drain();
    chk(got, 16'h5e);
    chk(tx_irq, 1'b1);
    apb(1'b0, 8'h0c, 0);
    chk(r, 32'hf0);
    apb(1'b0, 8'h0c, 0);
    chk(r, 32'h30);
    chk(rx_irq, 1'b0);
    apb(1'b0, 8'h08, 0);
    chk(r, 32'h9f);
    apb(1'b0, 8'h08, 0);
    chk(r, 32'h16);
    apb(1'b1, 8'h10, 32'h02);
    for (k = 0; k < 4; k++)
    begin
      apb(1'b0, 8'h04, 0);
      chk(r, (reply + m + k[15:0]) & 16'h00ff);
      apb(1'b0, 8'h0c, 0);
      chk(r, (k == 3) ? 32'h0 : 32'h20);
    end
    chk(tx_irq, 1'b1);
    // Engine reset in mid-word keeps the queued word
    apb(1'b1, 8'h10, 0);
    m = nwords[15:0];
    apb(1'b1, 8'h00, 32'h11);
    apb(1'b1, 8'h00, 32'h22);
    // Let the first word shift a few bits, with the serial clock high, before the reset
    repeat (28) @(posedge clk);
    apb(1'b1, 8'h18, 32'h0588);
    // Select drops again only after the reset edge has settled
    repeat (2) @(negedge clk);
    drain();
    chk(got, 16'h22);
    apb(1'b0, 8'h04, 0);
    chk(r, (reply + m) & 16'h00ff);
    test_done();
  end
endmodule

bind spi_master_status_fifo spi_master_status_fifo_chk #(.DW(DW), .DEPTH(DEPTH)) chk_i (.clk, .resetn,
  .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .spi_o, .tx_irq, .rx_irq);
